// ---- crw_pkg.sv ----
// package: register map, field layout and reset values of the result and wake threshold bank
package crw_pkg;
  // register indices (byte address is four times the index)
  localparam logic [7:0] CRW_IDX_CH1_RES_LOW  = 8'h08;
  localparam logic [7:0] CRW_IDX_CH1_RES_HIGH = 8'h09;
  localparam logic [7:0] CRW_IDX_CH2_RES_LOW  = 8'h0A;
  localparam logic [7:0] CRW_IDX_CH2_RES_HIGH = 8'h0B;
  localparam logic [7:0] CRW_IDX_CH1_ABS_THR  = 8'h0C;
  localparam logic [7:0] CRW_IDX_CH1_RATE_THR = 8'h0D;
  localparam logic [7:0] CRW_IDX_CH2_ABS_THR  = 8'h0E;
  localparam logic [7:0] CRW_IDX_CH2_RATE_THR = 8'h0F;
  localparam logic [7:0] CRW_IDX_CH1_WAKE_CFG = 8'h20;
  localparam logic [7:0] CRW_IDX_CH2_WAKE_CFG = 8'h21;
  localparam logic [7:0] CRW_IDX_WAKE_STATUS  = 8'h22;
  // field positions
  localparam int CRW_OVR_BIT     = 0;
  localparam int CRW_ABS_EN_BIT  = 0;
  localparam int CRW_RATE_EN_BIT = 1;
  localparam int CRW_COMBINE_BIT = 2;
  localparam int CRW_THR_LSB     = 4;
  localparam int CRW_CFG_W       = 3;
  // reset values
  localparam logic [7:0]  CRW_RST_REG8 = 8'h00;
  localparam logic [11:0] CRW_RST_RES  = 12'h000;
  localparam logic [2:0]  CRW_RST_CFG  = 3'h0;
  // bus answers
  localparam logic [1:0] CRW_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CRW_RESP_SLVERR = 2'b10;
  localparam logic [31:0] CRW_ZERO32 = 32'h0000_0000;
endpackage

// ---- crw_regs.sv ----
// module: result and wake threshold register bank with axi4-lite slave
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// Behaviour
// - ch1 result bits 11:4 in high register
// - ch2 result bits 3:0 at low bits 7:4
// - ch2 result bits 11:4 in high register
// - ch2 overrange flag follows each conversion
// - ch2 low register unused bits read zero
// - result registers read-only, writes ignored
// - results and ch1 absolute threshold reset zero
// - other thresholds reset to zero
// - ch1 absolute threshold steers standby wake
// - ch1 rate threshold steers standby wake
// - ch2 absolute threshold steers standby wake
// - ch2 rate threshold steers standby wake
// - disabled absolute detect ignores its threshold
// - disabled rate detect ignores its threshold
// - ch1 low register bit 0 overrange flag
// - enable bit turns absolute detection on
// - combine bit selects and versus or
//
// overview
// - two channels, each with a 12-bit result and overrange flag
// - results move in only on a conversion pulse
// - thresholds and wake config are plain software registers
// - wake status is sticky, write one to clear
//
// bus timing
// - awready, wready and arready are combinational
// - write answer one edge after address and data held
// - read answer at the same edge that takes the address
// - no new request taken on a channel while its answer waits
// - unmapped or misaligned access answers slverr
// - only byte lane 0 carries register data
//
// reset
// - arst_n asserts at once, releases after two edges
// - first request at the third edge after release
//
// clock enable
// - clk_en low freezes every register except the reset synchroniser, and every handshake
// - conversion pulses seen while frozen are lost
//
// limitations
// - the low nibble of the ch1 result is not shown
// - rate detect needs one earlier conversion
// - and-mode with no detector enabled never wakes
// - wake is judged on the incoming result
// - wake_event is a registered one-cycle pulse
// - awprot and arprot are ignored
// - wstrb lanes 1 to 3 are ignored
// - write data bits 31:8 are dropped
module crw_regs
  import crw_pkg::*;
#(
  parameter int RES_W  = 12,        // conversion result width
  parameter int ADDR_W = 12         // axi byte address width
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire logic              standby,
  input  wire logic [1:0]        conv_valid,
  input  wire logic [RES_W-1:0]  ch1_conv_result,
  input  wire logic [RES_W-1:0]  ch2_conv_result,
  input  wire logic [1:0]        conv_overrange,
  output logic [1:0]             wake_event,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // elaboration check: thresholds cover bits 11:4 of a 12-bit result
  if (RES_W != 12 || ADDR_W < 11) begin : g_chk
    $error("crw_regs: RES_W must be 12 and ADDR_W at least 11");
  end

  // reset release path:
  //   assertion reaches every register at once
  //   release is retimed by two flip-flops
  //   so no register leaves reset on a skewed edge
  // reset synchroniser
  logic rst_s1_q;                         // first stage
  logic rst_n_q;                          // released reset used everywhere
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // per-channel result storage and wake logic
  logic [RES_W-1:0] res_q   [2];        // latest conversion result
  logic [1:0]       ovr_q;              // overrange flags
  logic [1:0]       have_prev_q;        // a previous result exists
  logic [7:0]       abs_thr_q [2];      // absolute thresholds
  logic [7:0]       rate_thr_q [2];     // rate thresholds
  logic [CRW_CFG_W-1:0] cfg_q [2];      // enables and combine mode
  logic [1:0]       wake_q;             // wake pulses
  logic [1:0]       wake_seen_q;        // sticky wake status for software
  logic [RES_W-1:0] conv_res [2];       // incoming results as array
  logic [1:0]       wr_abs;             // write strobe per absolute threshold
  logic [1:0]       wr_rate;            // write strobe per rate threshold
  logic [1:0]       wr_cfg;             // write strobe per wake config
  logic             wr_status;          // write-one-to-clear of wake status
  logic [7:0]       wbyte;              // low write byte

  assign conv_res[0] = ch1_conv_result;
  assign conv_res[1] = ch2_conv_result;

  // per channel:
  //   capture register for result and overrange
  //   absolute compare against the stored threshold
  //   rate compare against the last stored result
  //   wake pulse one cycle after a hitting conversion in standby
  //   sticky status that software clears
  for (genvar c = 0; c < 2; c++) begin : g_ch
    // threshold widened to 12 bits, low nibble zero
    wire [RES_W-1:0] abs_thr12  = {abs_thr_q[c], 4'h0};
    wire [RES_W-1:0] rate_thr12 = {rate_thr_q[c], 4'h0};
    wire [RES_W-1:0] diff = (conv_res[c] >= res_q[c]) ?
                            (conv_res[c] - res_q[c]) : (res_q[c] - conv_res[c]);
    wire abs_en  = cfg_q[c][CRW_ABS_EN_BIT];
    wire rate_en = cfg_q[c][CRW_RATE_EN_BIT];
    wire comb    = cfg_q[c][CRW_COMBINE_BIT];
    // masked hits: a disabled detector contributes nothing
    wire abs_hit  = abs_en && (conv_res[c] > abs_thr12);
    wire rate_hit = rate_en && have_prev_q[c] && (diff > rate_thr12);
    // and-mode needs every enabled detector, or-mode any
    wire and_hit  = (abs_hit || !abs_en) && (rate_hit || !rate_en) && (abs_en || rate_en);
    wire hit      = comb ? and_hit : (abs_hit || rate_hit);
    wire take     = clk_en && conv_valid[c];

    // result capture and overrange flag per conversion
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        res_q[c]       <= CRW_RST_RES;
        ovr_q[c]       <= 1'b0;
        have_prev_q[c] <= 1'b0;
      end else if (take) begin
        res_q[c]       <= conv_res[c];
        ovr_q[c]       <= conv_overrange[c];
        have_prev_q[c] <= 1'b1;
      end
    end

    // threshold and config registers
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        abs_thr_q[c]  <= CRW_RST_REG8;
        rate_thr_q[c] <= CRW_RST_REG8;
        cfg_q[c]      <= CRW_RST_CFG;
      end else if (clk_en) begin
        if (wr_abs[c]) begin
          abs_thr_q[c] <= wbyte;
        end
        if (wr_rate[c]) begin
          rate_thr_q[c] <= wbyte;
        end
        if (wr_cfg[c]) begin
          cfg_q[c] <= wbyte[CRW_CFG_W-1:0];
        end
      end
    end

    // wake notes:
    //   the pulse needs standby, a conversion and a hit
    //   status keeps the hit until software clears it
    //   a hit and a clear in one cycle keep the bit set
    // wake pulse in standby, sticky status with set winning over clear
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        wake_q[c]      <= 1'b0;
        wake_seen_q[c] <= 1'b0;
      end else if (clk_en) begin
        wake_q[c] <= take && standby && hit;
        if (take && standby && hit) begin
          wake_seen_q[c] <= 1'b1;
        end else if (wr_status && wbyte[c]) begin
          wake_seen_q[c] <= 1'b0;
        end
      end
    end
  end

  assign wake_event = wake_q;

  // write path notes:
  //   address and data may arrive in either order
  //   each side is held until the other arrives
  //   the write lands at the edge after both are held
  //   bvalid rises at that same edge
  //   awready and wready stay low while bvalid stands
  //   result registers answer okay and stay unchanged
  //   a clear byte lane 0 makes the write a no-op
  // axi write channel: collect address and data in either order
  logic              aw_full_q;          // address held
  logic              w_full_q;           // data held
  logic [ADDR_W-1:0] awaddr_q;           // held write address
  logic [31:0]       wdata_q;            // held write data
  logic              wstrb0_q;           // low byte lane enabled
  logic              bvalid_q;           // write response pending
  logic [1:0]        bresp_q;            // write response code

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // write decode on the held address
  wire [7:0] wr_idx  = awaddr_q[9:2];
  wire       wr_go   = aw_full_q && w_full_q && !bvalid_q && clk_en;
  wire       wr_lane = wr_go && wstrb0_q;
  wire wr_is_res = (wr_idx == CRW_IDX_CH1_RES_LOW) || (wr_idx == CRW_IDX_CH1_RES_HIGH) ||
                   (wr_idx == CRW_IDX_CH2_RES_LOW) || (wr_idx == CRW_IDX_CH2_RES_HIGH);
  wire wr_mapped = (wr_idx == CRW_IDX_CH1_ABS_THR) || (wr_idx == CRW_IDX_CH1_RATE_THR) ||
                   (wr_idx == CRW_IDX_CH2_ABS_THR) || (wr_idx == CRW_IDX_CH2_RATE_THR) ||
                   (wr_idx == CRW_IDX_CH1_WAKE_CFG) || (wr_idx == CRW_IDX_CH2_WAKE_CFG) ||
                   (wr_idx == CRW_IDX_WAKE_STATUS) || wr_is_res;
  wire wr_aligned = (awaddr_q[1:0] == 2'b00) && (awaddr_q[ADDR_W-1:10] == '0);
  assign wbyte      = wdata_q[7:0];
  // results have no write strobe at all, so writes leave them intact
  assign wr_abs[0]  = wr_lane && wr_aligned && (wr_idx == CRW_IDX_CH1_ABS_THR);
  assign wr_abs[1]  = wr_lane && wr_aligned && (wr_idx == CRW_IDX_CH2_ABS_THR);
  assign wr_rate[0] = wr_lane && wr_aligned && (wr_idx == CRW_IDX_CH1_RATE_THR);
  assign wr_rate[1] = wr_lane && wr_aligned && (wr_idx == CRW_IDX_CH2_RATE_THR);
  assign wr_cfg[0]  = wr_lane && wr_aligned && (wr_idx == CRW_IDX_CH1_WAKE_CFG);
  assign wr_cfg[1]  = wr_lane && wr_aligned && (wr_idx == CRW_IDX_CH2_WAKE_CFG);
  assign wr_status  = wr_lane && wr_aligned && (wr_idx == CRW_IDX_WAKE_STATUS);

  // write channel state
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= CRW_ZERO32;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= CRW_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        // result registers answer okay but keep contents
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_mapped && wr_aligned) ? CRW_RESP_OKAY : CRW_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read map, one register per word, bits 31:8 zero:
  //   0x20 ch1 low: bit 0 overrange
  //   0x24 ch1 high: result bits 11:4
  //   0x28 ch2 low: result bits 3:0 on 7:4, bit 0 overrange
  //   0x2c ch2 high: result bits 11:4
  //   0x30 ch1 absolute threshold
  //   0x34 ch1 rate threshold
  //   0x38 ch2 absolute threshold
  //   0x3c ch2 rate threshold
  //   0x80 ch1 wake config, 0x84 ch2 wake config
  //   0x88 wake status, one bit per channel
  //   anything else: slverr and zero data
  // read mux
  wire [7:0] rd_idx     = s_axi_araddr[9:2];
  wire       rd_aligned = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[ADDR_W-1:10] == '0);
  wire [7:0] ch1_low    = {7'h00, ovr_q[0]};
  wire [7:0] ch1_high   = res_q[0][11:CRW_THR_LSB];
  wire [7:0] ch2_low    = {res_q[1][3:0], 3'h0, ovr_q[1]};
  wire [7:0] ch2_high   = res_q[1][11:CRW_THR_LSB];
  logic [7:0] rd_byte;                  // selected register value
  logic       rd_hit;                   // address maps to a register
  always_comb begin
    rd_hit  = rd_aligned;
    rd_byte = CRW_RST_REG8;
    case (rd_idx)
      CRW_IDX_CH1_RES_LOW:  rd_byte = ch1_low;
      CRW_IDX_CH1_RES_HIGH: rd_byte = ch1_high;
      CRW_IDX_CH2_RES_LOW:  rd_byte = ch2_low;
      CRW_IDX_CH2_RES_HIGH: rd_byte = ch2_high;
      CRW_IDX_CH1_ABS_THR:  rd_byte = abs_thr_q[0];
      CRW_IDX_CH1_RATE_THR: rd_byte = rate_thr_q[0];
      CRW_IDX_CH2_ABS_THR:  rd_byte = abs_thr_q[1];
      CRW_IDX_CH2_RATE_THR: rd_byte = rate_thr_q[1];
      CRW_IDX_CH1_WAKE_CFG: rd_byte = {5'h00, cfg_q[0]};
      CRW_IDX_CH2_WAKE_CFG: rd_byte = {5'h00, cfg_q[1]};
      CRW_IDX_WAKE_STATUS:  rd_byte = {6'h00, wake_seen_q};
      default:              rd_hit  = 1'b0;
    endcase
  end

  // read path notes:
  //   the address is decoded straight from the bus
  //   data is registered at the edge that takes it
  //   rvalid stands until rready is seen high
  //   arready is low while rvalid stands
  //   so one read at most is in flight
  // read channel state
  logic        rvalid_q;                // read data pending
  logic [31:0] rdata_q;                 // read data
  logic [1:0]  rresp_q;                 // read response
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q  <= CRW_ZERO32;
      rresp_q  <= CRW_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_hit ? {24'h00_0000, rd_byte} : CRW_ZERO32;
        rresp_q  <= rd_hit ? CRW_RESP_OKAY : CRW_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

// ---- crw_regs_checker.sv ----
// checker: bus answer and wake pulse properties of the register bank
`timescale 1ns/1ps
module crw_regs_checker (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic        standby,
  input wire logic [1:0]  conv_valid,
  input wire logic [1:0]  wake_event,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // both write channels taken at one edge
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en; endsequence
  // read address taken
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready && clk_en; endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read answer late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken while b pending");
  a_wake_one: assert property (wake_event[0] |-> $past(conv_valid[0]) && $past(standby)) else $error("ch1 wake cause");
  a_wake_two: assert property (wake_event[1] |-> $past(conv_valid[1]) && $past(standby)) else $error("ch2 wake cause");
endmodule
bind crw_regs crw_regs_checker u_crw_regs_checker (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
  .standby(standby), .conv_valid(conv_valid), .wake_event(wake_event), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ---- crw_front_model.sv ----
// model: conversion front end feeding results to the register bank
`timescale 1ns/1ps
module crw_front_model (
  input  wire logic   ref_clk,
  output logic [1:0]  conv_valid,
  output logic [11:0] ch1_res,
  output logic [11:0] ch2_res,
  output logic [1:0]  ovr
);
  // idle: no pulse, data lines carry junk
  initial begin
    conv_valid = 2'b00;
    ch1_res = 12'hA5A;
    ch2_res = 12'h5A5;
    ovr = 2'b10;
  end
  // one-cycle pulse on channel c; data inverted once it ends
  task automatic fire(input int c, input logic [11:0] v, input logic o);
    @(posedge ref_clk);
    conv_valid <= 2'(1 << c);
    {ch1_res, ch2_res, ovr} <= {v, v, o, o};
    @(posedge ref_clk);
    conv_valid <= 2'b00;
    {ch1_res, ch2_res, ovr} <= ~{v, v, o, o};
  endtask
endmodule

// ---- crw_regs_bench.sv ----
// testbench: register map, conversion capture and standby wake
`timescale 1ns/1ps
module crw_regs_bench;
  import crw_pkg::*;
  logic        ref_clk = 1'b0;  // 100 MHz
  logic        arst_n  = 1'b0;  // reset, low at start
  logic        standby = 1'b0;  // wake only counts here
  logic [1:0]  conv_valid, ovr, wake_event, bresp, rresp, r;
  logic [11:0] ch1_res, ch2_res, awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  int          err_count = 0;
  int          num_checks = 0;
  logic [11:0] res [2], pv [2];  // results, previous results
  logic        ro [2], hp [2];   // overrange, prior conversion seen
  logic [7:0]  thr [4];          // thresholds
  logic [2:0]  cfg [2];          // wake configuration
  logic [1:0]  ws;               // sticky wake status
  logic [15:0] tbl [9] = '{16'h1400, 16'h1401, 16'h0FFF, 16'h2000, 16'h2100, 16'h2201, 16'h7500, 16'h7501, 16'h3502};
  always #5 ref_clk = ~ref_clk;
  crw_regs u_crw_regs (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1), .standby(standby), .conv_valid(conv_valid),
    .ch1_conv_result(ch1_res), .ch2_conv_result(ch2_res), .conv_overrange(ovr), .wake_event(wake_event),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  crw_front_model u_crw_front_model (.ref_clk(ref_clk), .conv_valid(conv_valid), .ch1_res(ch1_res),
    .ch2_res(ch2_res), .ovr(ovr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // write: both channels offered, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic pa, pw, t1, t2;
    pa = 1;
    pw = 1;
    {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
    while (pa | pw) begin
      @(negedge ref_clk);
      {t1, t2} = {awready, wready};
      @(posedge ref_clk);
      if (t1 && pa) begin awvalid <= 0; pa = 0; end
      if (t2 && pw) begin wvalid <= 0; pw = 0; end
    end
    repeat ($urandom_range(0, 2)) @(posedge ref_clk);
    bready <= 1;
    do begin @(negedge ref_clk); t1 = bvalid; @(posedge ref_clk); end while (!t1);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    logic t;
    {araddr, arvalid} <= {a, 1'b1};
    do begin @(negedge ref_clk); t = arready; @(posedge ref_clk); end while (!t);
    arvalid <= 0;
    repeat ($urandom_range(0, 2)) @(posedge ref_clk);
    rready <= 1;
    do begin @(negedge ref_clk); t = rvalid; @(posedge ref_clk); end while (!t);
    {d, r} = {rdata, rresp};
    rready <= 0;
  endtask
  // expected register contents
  function automatic logic [31:0] exp_reg(input int i);
    case (i)
      8: return {31'h0, ro[0]};
      9: return {24'h0, res[0][11:4]};
      10: return {24'h0, res[1][3:0], 3'h0, ro[1]};
      11: return {24'h0, res[1][11:4]};
      default: return {24'h0, thr[i-12]};
    endcase
  endfunction
  // expected wake for a conversion of v on channel c
  function automatic logic exp_hit(input int c, input logic [11:0] v);
    logic a, t;
    a = cfg[c][0] && v > {thr[2*c], 4'h0};
    t = cfg[c][1] && hp[c] && ((v > pv[c]) ? v - pv[c] : pv[c] - v) > {thr[2*c+1], 4'h0};
    return standby && ((cfg[c] == 3'h7) ? a && t : a || t);
  endfunction
  task automatic put(input int i, input logic [7:0] v);
    wr(12'(4 * i), {24'h0, v});
    chk({30'h0, r}, {30'h0, CRW_RESP_OKAY});
    if (i >= 12 && i < 16) thr[i-12] = v;
    if (i >= 32) cfg[i-32] = v[2:0];
  endtask
  task automatic conv(input int c, input logic [11:0] v, input logic o);
    logic e;
    e = exp_hit(c, v);
    u_crw_front_model.fire(c, v, o);
    #1 chk({31'h0, wake_event[c]}, {31'h0, e});
    {res[c], pv[c], ro[c], hp[c]} = {v, v, o, 1'b1};
    if (e) ws[c] = 1'b1;
  endtask
  task automatic rst_chk();
    arst_n <= 0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1;
    repeat (3) @(posedge ref_clk);
    foreach (thr[k]) thr[k] = 0;
    ws = 2'b00;
    for (int k = 0; k < 2; k++) {res[k], pv[k], ro[k], hp[k], cfg[k]} = 0;
    for (int i = 8; i < 16; i++) begin rd(12'(4 * i)); chk(d, exp_reg(i)); end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(16));
    rst_chk();
    rd(12'h040);
    chk({30'h0, r}, {30'h0, CRW_RESP_SLVERR});
    chk(d, CRW_ZERO32);
    standby <= 1;
    for (int c = 0; c < 2; c++) begin
      put(12 + 2 * c, 8'h40);
      put(13 + 2 * c, 8'h10);
      foreach (tbl[k]) begin
        put(32 + c, {5'h0, tbl[k][14:12]});
        conv(c, tbl[k][11:0], 1'b0);
      end
    end
    for (int n = 0; n < 60; n++) begin
      standby <= 1'($urandom);
      put(12 + $urandom_range(0, 3), 8'($urandom));
      put(32 + n % 2, 8'($urandom_range(0, 7)));
      conv(n % 2, 12'($urandom), 1'($urandom));
      for (int i = 8; i < 16; i++) begin rd(12'(4 * i)); chk(d, exp_reg(i)); end
      rd(12'h088);
      chk(d, {30'h0, ws});
      if (n % 4 == 3) begin
        wr(12'h088, 32'h0000_0003);
        chk({30'h0, r}, {30'h0, CRW_RESP_OKAY});
        ws = 2'b00;
      end
    end
    put(9, 8'hFF);
    rd(12'h024);
    chk(d, exp_reg(9));
    standby <= 0;
    rst_chk();
    report_and_stop();
  end
  // watchdog against a hung handshake
  initial begin
    #500_000;
    err_count++;
    report_and_stop();
  end
endmodule
